//--- design/adc_demux_output_capture.sv
`default_nettype none
// Operation
// - two 8-bit ports, true and complement outputs
// - demuxed ports change only at data-ready rising edge
// - data-ready falls mid data window; held high in undivided mode
// - single-ended input gives straight binary
// - differential full scale at half swing
// - one overrange flag, true and complement
// - reset input clears internal demultiplexer
// - reset output follows internal demux reset
// - half-rate mode: two samples per period
// - quarter mode drops every other sample
// - undivided mode: primary only, aux idle, aux complement off unless both enables set
// - overrange from either port when demuxed
module adc_demux_output_capture
  import adc_demux_pkg::*;
(
  input  wire logic        clk,                 // converter sample clock
  input  wire logic        srst,                // sync reset
  input  wire logic        diff_input,          // differential drive selected
  input  wire logic [9:0]  raw_level,           // analog level, offset binary
  input  wire logic        demux_select_on,     // demultiplexer enable
  input  wire logic [1:0]  rate_divide_select,  // divide by two or four
  input  wire logic        aux_port_on_a,       // auxiliary port enable a
  input  wire logic        aux_port_on_b,       // auxiliary port enable b
  input  wire logic        demux_reset_in,      // demux reset input
  output logic [7:0]       primary_byte_port,   // primary port true
  output logic [7:0]       primary_byte_port_n, // primary port complement
  output logic [7:0]       auxiliary_byte_port, // auxiliary port true
  output logic [7:0]       auxiliary_byte_port_n, // auxiliary port complement
  output logic             overrange,           // overrange true
  output logic             overrange_n,         // overrange complement
  output logic             data_ready_clock,    // data-ready true phase
  output logic             data_ready_clock_n,  // data-ready complement phase
  output logic             demux_reset_out,     // reset output true
  output logic             demux_reset_out_n    // reset output complement
);

  // ----------------------------------------------------------------
  // mode decode and sampling
  // ----------------------------------------------------------------
  demux_mode_t mode;                            // decoded demux mode
  sample_t     cur;                             // newest converted sample
  sample_t     held_reg;                        // earlier sample of a pair
  logic [1:0]  phase_reg;                       // position within output period
  logic        aux_on;                          // auxiliary port powered
  logic        demux_rst;                       // internal demux reset
  logic        period_end;                      // last sample of the period
  logic        take_early;                      // hold this sample as primary

  // mode from enable and rate select
  always_comb
  begin
    if (!demux_select_on)
      mode = undivided_mode;
    else if (rate_divide_select == DIV_SEL_FOUR)
      mode = quarter_rate_decimate_mode;
    else
      mode = half_rate_mode;
  end

  assign aux_on    = aux_port_on_a & aux_port_on_b;
  assign demux_rst = srst | demux_reset_in;

  // phase positions: /1 every cycle ends, /2 ends at 1, /4 ends at 3
  always_comb
  begin
    unique case (mode)
      undivided_mode:             period_end = 1'b1;
      half_rate_mode:             period_end = phase_reg[0];
      quarter_rate_decimate_mode: period_end = (phase_reg == 2'h3);
      default:                    period_end = 1'b1;
    endcase
    take_early = (mode == half_rate_mode) ? (phase_reg[0] == 1'b0)
               : (phase_reg == 2'h1);
  end

  // converter core
  sample_quantizer u_quant (
    .clk        (clk),
    .srst       (srst),
    .diff_input (diff_input),
    .raw_level  (raw_level),
    .sample     (cur)
  );

  // ----------------------------------------------------------------
  // demultiplexer phase
  // ----------------------------------------------------------------
  // phase counter, cleared by the demux reset
  always_ff @(posedge clk)
  begin
    if (demux_rst)
      phase_reg <= PHASE_RESET;
    else if (mode == undivided_mode)
      phase_reg <= PHASE_RESET;
    else if (period_end)
      phase_reg <= PHASE_RESET;
    else
      phase_reg <= 2'(phase_reg + 2'h1);
  end

  // earlier sample of the pair; in quarter mode phase 0 and 2 are dropped
  always_ff @(posedge clk)
  begin
    if (demux_rst)
      held_reg <= '0;
    else if (mode != undivided_mode && take_early)
      held_reg <= cur;
  end

  // ----------------------------------------------------------------
  // output ports
  // ----------------------------------------------------------------
  // ports update together at period end, when data-ready rises in the demuxed modes
  always_ff @(posedge clk)
  begin
    if (demux_rst)
    begin
      primary_byte_port     <= PORT_RESET;
      primary_byte_port_n   <= ~PORT_RESET;
      auxiliary_byte_port   <= PORT_RESET;
      auxiliary_byte_port_n <= ~PORT_RESET;
      overrange             <= 1'b0;
      overrange_n           <= 1'b1;
    end
    else if (period_end)
    begin
      if (mode == undivided_mode)
      begin
        primary_byte_port     <= cur.code;
        primary_byte_port_n   <= ~cur.code;
        auxiliary_byte_port   <= PORT_RESET;
        auxiliary_byte_port_n <= aux_on ? ~PORT_RESET : PORT_RESET;
        overrange             <= cur.over;
        overrange_n           <= ~cur.over;
      end
      else
      begin
        primary_byte_port     <= held_reg.code;
        primary_byte_port_n   <= ~held_reg.code;
        auxiliary_byte_port   <= cur.code;
        auxiliary_byte_port_n <= ~cur.code;
        overrange             <= held_reg.over | cur.over;
        overrange_n           <= ~(held_reg.over | cur.over);
      end
    end
  end

  // data-ready: held high undivided; demuxed, rises with the data, falls mid period
  always_ff @(posedge clk)
  begin
    if (demux_rst)
    begin
      data_ready_clock   <= 1'b0;
      data_ready_clock_n <= 1'b1;
    end
    else if (mode == undivided_mode)
    begin
      data_ready_clock   <= 1'b1;
      data_ready_clock_n <= 1'b0;
    end
    else
    begin
      data_ready_clock   <= period_end | (phase_reg == 2'h0 &&
                            mode == quarter_rate_decimate_mode);
      data_ready_clock_n <= ~(period_end | (phase_reg == 2'h0 &&
                            mode == quarter_rate_decimate_mode));
    end
  end

  // reset output follows the internal demux reset
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      demux_reset_out   <= 1'b1;
      demux_reset_out_n <= 1'b0;
    end
    else
    begin
      demux_reset_out   <= demux_reset_in;
      demux_reset_out_n <= ~demux_reset_in;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  port_stable_a : assert property (@(posedge clk) disable iff (demux_rst)
    (!$past(period_end) && !$past(demux_rst)) |-> $stable(primary_byte_port))
    else $error("primary port changed off the update edge");
  comp_pair_a : assert property (@(posedge clk) disable iff (srst)
    primary_byte_port_n == ~primary_byte_port)
    else $error("primary complement mismatch");
  or_pair_a : assert property (@(posedge clk) disable iff (srst)
    overrange_n == ~overrange)
    else $error("overrange complement mismatch");
  rst_clear_a : assert property (@(posedge clk)
    demux_reset_in |=> phase_reg == PHASE_RESET)
    else $error("demux not reset");
  rst_follow_a : assert property (@(posedge clk) disable iff (srst)
    demux_reset_in |=> demux_reset_out && !demux_reset_out_n)
    else $error("reset output did not follow");
  half_period_a : assert property (@(posedge clk) disable iff (demux_rst)
    (mode == half_rate_mode && $stable(mode) && period_end)
      |=> !period_end ##1 period_end)
    else $error("half rate period wrong");
  quarter_period_a : assert property (@(posedge clk) disable iff (demux_rst)
    (mode == quarter_rate_decimate_mode && $stable(mode) && period_end)
      |=> !period_end [*3] ##1 period_end)
    else $error("quarter rate period wrong");
  aux_direct_a : assert property (@(posedge clk) disable iff (demux_rst)
    (mode == undivided_mode && $stable(mode)) |=> auxiliary_byte_port == PORT_RESET)
    else $error("aux active in undivided mode");
  or_either_a : assert property (@(posedge clk) disable iff (demux_rst)
    (mode != undivided_mode && period_end && (held_reg.over | cur.over))
      |=> overrange)
    else $error("overrange missed");

endmodule // adc_demux_output_capture
`default_nettype wire

//--- design/adc_demux_pkg.sv
`default_nettype none
package adc_demux_pkg;

  // ----------------------------------------------------------------
  // widths and codes
  // ----------------------------------------------------------------
  localparam int unsigned SAMPLE_W = 8;                       // sample byte width
  localparam logic [7:0] CODE_FULL_SCALE = 8'hFF;             // positive full scale
  localparam logic [7:0] CODE_ZERO_SCALE = 8'h00;             // negative full scale
  localparam logic [7:0] CODE_MID_LOW    = 8'h7F;             // zero input, low code
  localparam logic [7:0] CODE_MID_HIGH   = 8'h80;             // zero input, high code
  localparam logic [1:0] DIV_SEL_TWO     = 2'h0;              // rate select: divide by two
  localparam logic [1:0] DIV_SEL_FOUR    = 2'h1;              // rate select: divide by four

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] PORT_RESET      = 8'h00;             // port value after reset
  localparam logic [1:0] PHASE_RESET     = 2'h0;              // demux phase after reset

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  // demultiplexer operating mode
  typedef enum logic [1:0] {
    undivided_mode             = 2'b00,
    half_rate_mode             = 2'b01,
    quarter_rate_decimate_mode = 2'b10
  } demux_mode_t;

  // one converted sample with its overrange flag
  typedef struct packed {
    logic       over;
    logic [7:0] code;
  } sample_t;

  // differential output pair
  typedef struct packed {
    logic [7:0] true_v;
    logic [7:0] comp_v;
  } diff_byte_t;

endpackage
`default_nettype wire

//--- design/sample_quantizer.sv
`default_nettype none
// ----------------------------------------------------------------
// sample quantizer: input value to straight binary code
// ----------------------------------------------------------------
module sample_quantizer
  import adc_demux_pkg::*;
(
  input  wire logic        clk,           // sample clock
  input  wire logic        srst,          // sync reset
  input  wire logic        diff_input,    // differential drive selected
  input  wire logic [9:0]  raw_level,     // signed input level, offset binary
  output var  sample_t     sample         // registered sample
);
  // raw_level is offset binary: 0x200 = zero input; single-ended
  // full scale spans 0x100..0x2FF at two levels per code,
  // differential half of that per side
  logic [9:0]  span_reg;                  // level after differential gain, centre stays at 0x200
  logic [10:0] scaled;                    // width for differential gain

  // differential swing per side is half: double the offset from centre
  always_comb
  begin
    if (diff_input && raw_level < 10'h100)
      scaled = 11'h000;                                           // clamp, no wrap below zero
    else if (diff_input)
      scaled = {1'b0, raw_level} + {1'b0, raw_level} - 11'h200;
    else
      scaled = {1'b0, raw_level};
    span_reg = scaled[9:0];
  end

  // clamp to code range, overrange only above full scale
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      sample <= '0;
    end
    else if (scaled >= 11'h2FF)
    begin
      sample.code <= CODE_FULL_SCALE;
      sample.over <= (scaled >= 11'h300);
    end
    else if (scaled < 11'h100)
    begin
      sample.code <= CODE_ZERO_SCALE;
      sample.over <= 1'b0;
    end
    else
    begin
      sample.code <= 8'((span_reg - 10'h100) >> 1);
      sample.over <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  over_full_a : assert property (@(posedge clk) disable iff (srst)
    sample.over |-> sample.code == CODE_FULL_SCALE)
    else $error("overrange without full-scale code");
  neg_zero_a : assert property (@(posedge clk) disable iff (srst)
    (!diff_input && raw_level == 10'h000) |=> sample.code == CODE_ZERO_SCALE)
    else $error("negative full scale not zero code");
  mid_code_a : assert property (@(posedge clk) disable iff (srst)
    (raw_level == 10'h200) |=> sample.code == CODE_MID_HIGH && !sample.over)
    else $error("zero input wrong code");

endmodule // sample_quantizer
`default_nettype wire

//--- verif/adc_demux_output_capture_tb.sv
`default_nettype none
`define CHK(what, exp, got) begin checks++; if ((got) !== (exp)) begin miscompares++; \
  $display("Error %s expected %h seen %h", what, exp, got); end end
module adc_demux_output_capture_tb
  import adc_demux_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  // ----------------------------------------------------------------
  // stimulus and observed signals
  // ----------------------------------------------------------------
  logic       clk = 1'b0, srst = 1'b1, diff_input = 1'b0, demux_select_on = 1'b1;
  logic       aux_port_on_a = 1'b1, aux_port_on_b = 1'b1, demux_reset_in = 1'b0;
  logic [9:0] raw_level = 10'h200;                  // zero input
  logic [1:0] rate_divide_select = DIV_SEL_TWO;
  logic [7:0] prim, prim_n, aux, aux_n, prev_prim;  // port values
  logic       ovr, ovr_n, dr, dr_n, rst_o, rst_o_n, prev_dr;
  logic       ramp_on = 1'b0, alt_on = 1'b0, mon_on = 1'b0;
  sample_t    earlier, later, comp_later;           // captured pair
  int         captures, miscompares = 0, checks = 0, cycles = 0, start;

  always #2.5 clk = ~clk;

  adc_demux_output_capture dut (.clk(clk), .srst(srst), .diff_input(diff_input),
    .raw_level(raw_level), .demux_select_on(demux_select_on),
    .rate_divide_select(rate_divide_select), .aux_port_on_a(aux_port_on_a),
    .aux_port_on_b(aux_port_on_b), .demux_reset_in(demux_reset_in),
    .primary_byte_port(prim), .primary_byte_port_n(prim_n),
    .auxiliary_byte_port(aux), .auxiliary_byte_port_n(aux_n), .overrange(ovr),
    .overrange_n(ovr_n), .data_ready_clock(dr), .data_ready_clock_n(dr_n),
    .demux_reset_out(rst_o), .demux_reset_out_n(rst_o_n));

  capture_model cap (.data_ready_clock(dr), .data_ready_clock_n(dr_n),
    .primary_byte_port(prim), .auxiliary_byte_port(aux), .overrange(ovr),
    .auxiliary_byte_port_n(aux_n), .overrange_n(ovr_n), .earlier(earlier),
    .later(later), .comp_later(comp_later), .captures(captures));

  // ----------------------------------------------------------------
  // level engine: ramp one code per clock, or toggle two levels
  // ----------------------------------------------------------------
  always @(posedge clk)
  begin
    if (ramp_on)
      raw_level <= raw_level + 10'h002;             // two levels per code
    else if (alt_on)
      raw_level <= raw_level ^ 10'h180;             // swaps 300 and 280
  end

  // port watch and hang limit
  always @(negedge clk)
  begin
    cycles++;
    if (cycles > 3000)
    begin
      miscompares++;
      tally_and_finish();
    end
    if (mon_on && prim !== prev_prim)
      `CHK("change at ready rise", 2'b10, {dr, prev_dr})
    prev_prim = prim;
    prev_dr   = dr;
  end

  task automatic tally_and_finish();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // stop the level engine, then change mode with the demux reset raised
  task automatic set_mode(input logic dm, input logic [1:0] dv, input logic df,
                          input logic [9:0] lv);
    @(posedge clk);
    ramp_on <= 1'b0; alt_on <= 1'b0; mon_on <= 1'b0;
    @(posedge clk);
    demux_select_on <= dm; rate_divide_select <= dv; diff_input <= df; raw_level <= lv;
    demux_reset_in <= 1'b1;
    @(posedge clk) demux_reset_in <= 1'b0;
  endtask

  task automatic wait_caps(input int n);
    int s;
    s = captures;
    repeat (100) if (captures < s + n) @(negedge clk);
    `CHK("capture count", 1'b1, captures >= s + n)
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_levels();
    logic [9:0] lv [5] = '{10'h000, 10'h100, 10'h2FF, 10'h300, 10'h180};
    sample_t    ex [5] = '{9'h000, 9'h000, 9'h0FF, 9'h1FF, 9'h040};
    for (int i = 0; i < 5; i++)
    begin
      set_mode(1'b1, DIV_SEL_TWO, 1'b0, lv[i]);
      wait_caps(3);
      `CHK("later sample", ex[i], later)
      `CHK("earlier sample", ex[i], earlier)
      `CHK("complement capture", later, comp_later)
      `CHK("aux complement", ~aux, aux_n)
      `CHK("over complement", ~ovr, ovr_n)
    end
  endtask

  task automatic t_diff();
    set_mode(1'b1, DIV_SEL_TWO, 1'b1, 10'h200);
    wait_caps(3);
    `CHK("mid code", 1'b1, later.code === 8'h7F || later.code === 8'h80)
    `CHK("mid over", 1'b0, later.over)
    set_mode(1'b1, DIV_SEL_TWO, 1'b1, 10'h0C0);
    wait_caps(3);
    `CHK("diff below zero", 9'h000, later)
    set_mode(1'b1, DIV_SEL_TWO, 1'b1, 10'h300);
    wait_caps(3);
    `CHK("diff full", 9'h1FF, later)
  endtask

  task automatic t_ramp(input logic [1:0] dv, input logic [7:0] step, input int per);
    set_mode(1'b1, dv, 1'b0, 10'h140);
    @(posedge clk) ramp_on <= 1'b1;
    mon_on <= 1'b1;
    wait_caps(3);
    `CHK("pair order", earlier.code + step, later.code)
    start = captures;
    repeat (16) @(negedge clk);
    `CHK("ready rate", 16 / per, captures - start)
  endtask

  task automatic t_over();
    set_mode(1'b1, DIV_SEL_TWO, 1'b0, 10'h300);
    @(posedge clk) alt_on <= 1'b1;
    wait_caps(3);
    `CHK("pair over", 1'b1, later.over)
    `CHK("pair codes", 8'h3F, earlier.code ^ later.code)
    set_mode(1'b0, DIV_SEL_FOUR, 1'b0, 10'h300);
    @(posedge clk) alt_on <= 1'b1;
    repeat (6)
    begin
      @(negedge clk);
      `CHK("primary over", prim === 8'hFF, ovr)
      `CHK("aux idle", 8'h00, aux)
      `CHK("aux comp on", 8'hFF, aux_n)
    end
    @(posedge clk) aux_port_on_a <= 1'b0;
    repeat (2) @(negedge clk);
    `CHK("aux comp off", 8'h00, aux_n)
    @(posedge clk) aux_port_on_a <= 1'b1;
  endtask

  task automatic t_demux_reset();
    set_mode(1'b1, DIV_SEL_TWO, 1'b0, 10'h2FF);
    wait_caps(2);
    @(posedge clk) demux_reset_in <= 1'b1;
    @(posedge clk) demux_reset_in <= 1'b0;
    @(negedge clk);
    `CHK("reset ports", 16'h00FF, {prim, prim_n})
    `CHK("reset ready", 1'b0, dr)
    `CHK("reset out", 2'b10, {rst_o, rst_o_n})
    @(negedge clk);
    `CHK("reset out end", 2'b01, {rst_o, rst_o_n})
  endtask

  initial
  begin
    repeat (2) @(posedge clk);
    @(negedge clk);
    `CHK("srst ports", 16'h00FF, {prim, prim_n})
    `CHK("srst over", 1'b0, ovr)
    `CHK("srst reset out", 1'b1, rst_o)
    @(posedge clk) srst <= 1'b0;
    t_levels();
    t_diff();
    t_ramp(DIV_SEL_TWO, 8'h01, 2);
    t_ramp(DIV_SEL_FOUR, 8'h02, 4);
    t_over();
    t_demux_reset();
    tally_and_finish();
  end
endmodule // adc_demux_output_capture_tb
`default_nettype wire

//--- verif/capture_model.sv
`default_nettype none
// ----------------------------------------------------------------
// far-side capture logic, latching each output pair
// ----------------------------------------------------------------
module capture_model
  import adc_demux_pkg::*;
(
  input  wire logic       data_ready_clock,      // true phase, acquisition clock
  input  wire logic       data_ready_clock_n,    // complement phase
  input  wire logic [7:0] primary_byte_port,     // primary true bits
  input  wire logic [7:0] auxiliary_byte_port,   // auxiliary true bits
  input  wire logic       overrange,             // overrange true
  input  wire logic [7:0] auxiliary_byte_port_n, // auxiliary complement bits
  input  wire logic       overrange_n,           // overrange complement
  output var  sample_t    earlier,               // first sample of the pair
  output var  sample_t    later,                 // second sample of the pair
  output var  sample_t    comp_later,            // later sample via complement clock
  output var  int         captures               // pairs latched so far
);
  timeunit 1ns;
  timeprecision 1ps;

  initial captures = 0;

  // true phase: latch at the falling edge, no added delay
  always @(negedge data_ready_clock)
  begin
    earlier  <= {overrange, primary_byte_port};    // earlier sample first
    later    <= {overrange, auxiliary_byte_port};  // auxiliary is the later one
    captures <= captures + 1;
  end

  // complement phase: rising edge, every bit from the complement side
  always @(posedge data_ready_clock_n)
  begin
    comp_later <= {~overrange_n, ~auxiliary_byte_port_n};
  end
endmodule // capture_model
`default_nettype wire
